// ---- rtl/smie_exec.sv ----
// The Wishbone register port and the placing of the registers were left to the implementer.
`timescale 1ns/100ps
module smie_exec
	import smie_pkg::*;
(
	// Clock and reset
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	// Wishbone slave
	input  wire logic        wb_cyc_i,
	input  wire logic        wb_stb_i,
	input  wire logic        wb_we_i,
	input  wire logic [7:0]  wb_adr_i,
	input  wire logic [3:0]  wb_sel_i,
	input  wire logic [31:0] wb_dat_i,
	output logic      [31:0] wb_dat_o,
	output logic             wb_ack_o,
	// Core state
	output logic      [7:0]  acc_o,
	output logic             carry_o,
	output logic             zero_o,
	output logic      [4:0]  bank_o,
	output logic      [6:0]  pc_latch_o,
	output logic      [12:0] pc_o
);

	// ************************************************************
	// Helpers
	// ************************************************************
	function automatic logic [31:0] merge_lanes(input logic [31:0] old_v,
		input logic [31:0] new_v, input logic [3:0] sel);
		logic [31:0] r;
		r = old_v;
		for (int i = 0; i < 4; i++)
		begin
			if (sel[i])
				r[8*i +: 8] = new_v[8*i +: 8];
		end
		return r;
	endfunction : merge_lanes

	function automatic logic is_window(input logic [6:0] idx);
		return (idx == WINDOW0_IDX) || (idx == WINDOW1_IDX);
	endfunction : is_window

	// ************************************************************
	// State
	// ************************************************************
	logic [7:0]  file_mem [FILE_DEPTH];
	logic [7:0]  acc_reg,    acc_next;
	logic        carry_reg,  carry_next;
	logic        zero_reg,   zero_next;
	logic [4:0]  bank_reg,   bank_next;
	logic [6:0]  latch_reg,  latch_next;
	logic [15:0] ptr0_reg,   ptr0_next;
	logic [15:0] ptr1_reg,   ptr1_next;
	logic [12:0] pc_reg,     pc_next;
	logic [6:0]  faddr_reg,  faddr_next;
	logic        ack_reg,    ack_next;
	logic [31:0] rdata_reg,  rdata_next;
	logic        mem_we;
	logic [6:0]  mem_waddr;
	logic [7:0]  mem_wdata;

	// ************************************************************
	// Decode of a command write
	// ************************************************************
	logic        req;
	logic        wr_take;
	logic        exec;
	smie_cmd_t   cmd;
	logic [6:0]  f_idx;
	logic [6:0]  src_idx;
	logic [7:0]  src_val;
	logic [15:0] ptr_sel_val;
	logic [15:0] ea;
	logic [15:0] ptr_upd;
	logic [7:0]  ind_val;
	logic [15:0] offset_ext;
	logic [31:0] ptr0_merge;

	assign req     = wb_cyc_i & wb_stb_i;
	assign wr_take = req & ack_reg & wb_we_i;
	assign exec    = wr_take & (wb_adr_i == ADR_CMD);
	assign cmd     = smie_cmd_t'(merge_lanes(32'h0000_0000, wb_dat_i, wb_sel_i));
	assign f_idx   = cmd.operand[6:0];
	assign ptr_sel_val = cmd.ptr_sel ? ptr1_reg : ptr0_reg;
	assign offset_ext  = {{10{cmd.operand[5]}}, cmd.operand[5:0]};
	assign ptr0_merge  = merge_lanes({16'h0, ptr0_reg}, wb_dat_i, wb_sel_i);

	// Window register names the cell its pointer holds
	always_comb
	begin
		if (f_idx == WINDOW0_IDX)
			src_idx = ptr0_reg[6:0];
		else if (f_idx == WINDOW1_IDX)
			src_idx = ptr1_reg[6:0];
		else
			src_idx = f_idx;
	end

	// A pointer aimed at a window cell reads zero to avoid a loop
	assign src_val = (is_window(f_idx) && is_window(src_idx)) ? 8'h00 : file_mem[src_idx];

	// Effective address and pointer write-back
	always_comb
	begin
		if (cmd.relative)
		begin
			ea      = ptr_sel_val + offset_ext;
			ptr_upd = ptr_sel_val;
		end
		else
		begin
			case (cmd.pointer_update_code)
				UPD_PRE_INC:
				begin
					ea      = ptr_sel_val + 16'h0001;
					ptr_upd = ea;
				end
				UPD_PRE_DEC:
				begin
					ea      = ptr_sel_val - 16'h0001;
					ptr_upd = ea;
				end
				UPD_POST_INC:
				begin
					ea      = ptr_sel_val;
					ptr_upd = ptr_sel_val + 16'h0001;
				end
				default:
				begin
					ea      = ptr_sel_val;
					ptr_upd = ptr_sel_val - 16'h0001;
				end
			endcase
		end
	end

	// Only the low seven bits reach the cell array
	assign ind_val = is_window(ea[6:0]) ? 8'h00 : file_mem[ea[6:0]];

	// ************************************************************
	// Next state
	// ************************************************************
	always_comb
	begin
		acc_next   = acc_reg;
		carry_next = carry_reg;
		zero_next  = zero_reg;
		bank_next  = bank_reg;
		latch_next = latch_reg;
		ptr0_next  = ptr0_reg;
		ptr1_next  = ptr1_reg;
		pc_next    = pc_reg;
		faddr_next = faddr_reg;
		mem_we     = 1'b0;
		mem_waddr  = src_idx;
		mem_wdata  = 8'h00;
		// Answer one cycle after the request, drop the next cycle
		ack_next   = req & ~ack_reg;
		rdata_next = rdata_reg;
		if (req & ~ack_reg)
		begin
			case (wb_adr_i)
				ADR_ACC:    rdata_next = {24'h0, acc_reg};
				ADR_STATUS: rdata_next = {30'h0, zero_reg, carry_reg};
				ADR_BANK:   rdata_next = {27'h0, bank_reg};
				ADR_LATCH:  rdata_next = {25'h0, latch_reg};
				ADR_PTR0:   rdata_next = {16'h0, ptr0_reg};
				ADR_PTR1:   rdata_next = {16'h0, ptr1_reg};
				ADR_PC:     rdata_next = {19'h0, pc_reg};
				ADR_FADDR:  rdata_next = {25'h0, faddr_reg};
				ADR_FDATA:  rdata_next = {24'h0, file_mem[faddr_reg]};
				default:    rdata_next = 32'h0000_0000;
			endcase
		end
		if (wr_take)
		begin
			case (wb_adr_i)
				ADR_ACC:    acc_next   = wb_dat_i[7:0];
				ADR_STATUS:
				begin
					carry_next = wb_dat_i[STAT_C_BIT];
					zero_next  = wb_dat_i[STAT_Z_BIT];
				end
				ADR_BANK:   bank_next  = wb_dat_i[4:0];
				ADR_LATCH:  latch_next = wb_dat_i[6:0];
				ADR_PTR0:   ptr0_next  = ptr0_merge[15:0];
				ADR_PTR1:   ptr1_next  = wb_dat_i[15:0];
				ADR_FADDR:  faddr_next = wb_dat_i[6:0];
				ADR_FDATA:
				begin
					mem_we    = 1'b1;
					mem_waddr = faddr_reg;
					mem_wdata = wb_dat_i[7:0];
				end
				ADR_CMD:
				begin
					case (smie_op_t'(cmd.op))
						OP_LOGIC_SHIFT_RIGHT:
						begin
							carry_next = src_val[0];
							zero_next  = (src_val[7:1] == 7'h00);
							if (cmd.dest)
							begin
								mem_we    = 1'b1;
								mem_wdata = {1'b0, src_val[7:1]};
							end
							else
								acc_next = {1'b0, src_val[7:1]};
						end
						OP_COPY_FILE:
						begin
							zero_next = (src_val == 8'h00);
							if (cmd.dest)
							begin
								mem_we    = 1'b1;
								mem_wdata = src_val;
							end
							else
								acc_next = src_val;
						end
						OP_INDIRECT_LOAD:
						begin
							acc_next  = ind_val;
							zero_next = (ind_val == 8'h00);
							// Carry left alone by the pointer update
							if (cmd.ptr_sel)
								ptr1_next = ptr_upd;
							else
								ptr0_next = ptr_upd;
						end
						OP_LITERAL_TO_BANK:
							bank_next = cmd.operand[4:0];
						OP_LITERAL_TO_PC_LATCH:
							latch_next = cmd.operand[6:0];
						OP_LITERAL_TO_ACC:
							acc_next = cmd.operand[7:0];
						OP_BRANCH:
							pc_next = {latch_reg[LATCH_HI:LATCH_LO], cmd.operand};
						default:
							acc_next = acc_reg;
					endcase
				end
				default:
					acc_next = acc_reg;
			endcase
		end
		// Window cells are not storage for commands; a command write-back aimed there is dropped (ADR_FDATA still writes them)
		if (mem_we && (wb_adr_i == ADR_CMD) && is_window(mem_waddr))
			mem_we = 1'b0;
	end

	// ************************************************************
	// Registers
	// ************************************************************
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			acc_reg   <= ACC_RST;
			carry_reg <= 1'b0;
			zero_reg  <= 1'b0;
			bank_reg  <= BANK_RST;
			latch_reg <= LATCH_RST;
			ptr0_reg  <= PTR_RST;
			ptr1_reg  <= PTR_RST;
			pc_reg    <= PC_RST;
			faddr_reg <= 7'h00;
			ack_reg   <= 1'b0;
			rdata_reg <= 32'h0000_0000;
		end
		else
		begin
			acc_reg   <= acc_next;
			carry_reg <= carry_next;
			zero_reg  <= zero_next;
			bank_reg  <= bank_next;
			latch_reg <= latch_next;
			ptr0_reg  <= ptr0_next;
			ptr1_reg  <= ptr1_next;
			pc_reg    <= pc_next;
			faddr_reg <= faddr_next;
			ack_reg   <= ack_next;
			rdata_reg <= rdata_next;
		end
	end

	// Cell array has no reset; contents are undefined until written
	always_ff @(posedge clk_i)
	begin
		if (mem_we)
			file_mem[mem_waddr] <= mem_wdata;
	end

	assign wb_ack_o   = ack_reg;
	assign wb_dat_o   = rdata_reg;
	assign acc_o      = acc_reg;
	assign carry_o    = carry_reg;
	assign zero_o     = zero_reg;
	assign bank_o     = bank_reg;
	assign pc_latch_o = latch_reg;
	assign pc_o       = pc_reg;

	// ************************************************************
	// Assertions
	// ************************************************************
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);

	logic is_shr;
	logic is_copy;
	logic is_iload;
	logic is_lit;
	assign is_shr   = exec && (cmd.op == OP_LOGIC_SHIFT_RIGHT);
	assign is_copy  = exec && (cmd.op == OP_COPY_FILE);
	assign is_iload = exec && (cmd.op == OP_INDIRECT_LOAD);
	assign is_lit   = exec && (cmd.op inside {OP_LITERAL_TO_BANK, OP_LITERAL_TO_PC_LATCH,
		OP_LITERAL_TO_ACC});

	property p_shr_acc;
		is_shr && !cmd.dest |=> acc_reg == ($past(src_val) >> 1) && carry_reg == $past(src_val[0]);
	endproperty
	a_shr_acc: assert property (p_shr_acc) else $error("shift result wrong");

	property p_shr_file;
		is_shr && cmd.dest && !is_window(src_idx) |=> $stable(acc_reg)
			&& file_mem[$past(src_idx)] == ($past(src_val) >> 1);
	endproperty
	a_shr_file: assert property (p_shr_file) else $error("shift write-back wrong");

	property p_copy_zero;
		is_copy && cmd.dest |=> zero_reg == ($past(src_val) == 8'h00);
	endproperty
	a_copy_zero: assert property (p_copy_zero) else $error("copy zero flag wrong");

	property p_copy_acc;
		is_copy && !cmd.dest |=> acc_reg == $past(src_val);
	endproperty
	a_copy_acc: assert property (p_copy_acc) else $error("copy to acc wrong");

	property p_postinc;
		is_iload && !cmd.relative && cmd.pointer_update_code == UPD_POST_INC && !cmd.ptr_sel
			|=> ptr0_reg == $past(ptr0_reg) + 16'h0001 && acc_reg == $past(ind_val);
	endproperty
	a_postinc: assert property (p_postinc) else $error("post-increment wrong");

	property p_rel_keep;
		is_iload && cmd.relative |=> $stable(ptr0_reg) && $stable(ptr1_reg);
	endproperty
	a_rel_keep: assert property (p_rel_keep) else $error("relative mode moved pointer");

	property p_ptr_carry;
		is_iload |=> $stable(carry_reg);
	endproperty
	a_ptr_carry: assert property (p_ptr_carry) else $error("pointer update hit carry");

	property p_lit_flags;
		is_lit |=> $stable(carry_reg) && $stable(zero_reg);
	endproperty
	a_lit_flags: assert property (p_lit_flags) else $error("literal load changed flags");

	property p_branch;
		exec && cmd.op == OP_BRANCH |=> pc_reg[12:11] == $past(latch_reg[LATCH_HI:LATCH_LO]);
	endproperty
	a_branch: assert property (p_branch) else $error("branch upper bits wrong");

	property p_ack_pulse;
		ack_reg |=> !ack_reg;
	endproperty
	a_ack_pulse: assert property (p_ack_pulse) else $error("ack longer than one cycle");

	property p_wrap;
		is_iload && !cmd.relative && cmd.pointer_update_code == UPD_PRE_INC && !cmd.ptr_sel
			&& ptr0_reg == 16'hffff |=> ptr0_reg == 16'h0000;
	endproperty
	a_wrap: assert property (p_wrap) else $error("pointer did not wrap");

	c_shr:    cover property (is_shr && cmd.dest);
	c_iload:  cover property (is_iload && cmd.relative);
	c_wrap:   cover property (is_iload && ptr0_reg == 16'h0000 && !cmd.relative
		&& cmd.pointer_update_code == UPD_POST_DEC);
	c_branch: cover property (exec && cmd.op == OP_BRANCH);

endmodule : smie_exec

// ---- rtl/smie_pkg.sv ----
package smie_pkg;

	// ************************************************************
	// Register map (byte addresses, one word each)
	// ************************************************************
	localparam logic [7:0] ADR_CMD    = 8'h00;
	localparam logic [7:0] ADR_ACC    = 8'h04;
	localparam logic [7:0] ADR_STATUS = 8'h08;
	localparam logic [7:0] ADR_BANK   = 8'h0c;
	localparam logic [7:0] ADR_LATCH  = 8'h10;
	localparam logic [7:0] ADR_PTR0   = 8'h14;
	localparam logic [7:0] ADR_PTR1   = 8'h18;
	localparam logic [7:0] ADR_PC     = 8'h1c;
	localparam logic [7:0] ADR_FADDR  = 8'h20;
	localparam logic [7:0] ADR_FDATA  = 8'h24;

	// ************************************************************
	// Fields and reset values
	// ************************************************************
	localparam int         STAT_C_BIT  = 0;
	localparam int         STAT_Z_BIT  = 1;
	localparam int         LATCH_HI    = 4;
	localparam int         LATCH_LO    = 3;
	localparam logic [7:0] ACC_RST     = 8'h00;
	localparam logic [4:0] BANK_RST    = 5'h00;
	localparam logic [6:0] LATCH_RST   = 7'h00;
	localparam logic [15:0] PTR_RST    = 16'h0000;
	localparam logic [12:0] PC_RST     = 13'h0000;
	localparam int         FILE_DEPTH  = 128;
	localparam logic [6:0] WINDOW0_IDX = 7'h00;
	localparam logic [6:0] WINDOW1_IDX = 7'h01;

	// ************************************************************
	// Pointer update codes
	// ************************************************************
	localparam logic [1:0] UPD_PRE_INC  = 2'b00;
	localparam logic [1:0] UPD_PRE_DEC  = 2'b01;
	localparam logic [1:0] UPD_POST_INC = 2'b10;
	localparam logic [1:0] UPD_POST_DEC = 2'b11;

	typedef enum logic [3:0] {
		OP_NOP                    = 4'h0,
		OP_LOGIC_SHIFT_RIGHT      = 4'h1,
		OP_COPY_FILE              = 4'h2,
		OP_INDIRECT_LOAD          = 4'h3,
		OP_LITERAL_TO_BANK        = 4'h4,
		OP_LITERAL_TO_PC_LATCH    = 4'h5,
		OP_LITERAL_TO_ACC         = 4'h6,
		OP_BRANCH                 = 4'h7
	} smie_op_t;

	// Command word layout
	typedef struct packed {
		logic [4:0]  unused_hi;
		logic [10:0] operand;
		logic [6:0]  unused_lo;
		logic        relative;
		logic [1:0]  pointer_update_code;
		logic        ptr_sel;
		logic        dest;
		logic [3:0]  op;
	} smie_cmd_t;

endpackage : smie_pkg

// ---- tb/tb.sv ----
`timescale 1ns/100ps
module tb;
	import smie_pkg::*;
	// ********************
	// Clock, reset and bus
	// ********************
	logic        clk_i;
	logic        rst_i;
	logic        wb_cyc_i;
	logic        wb_stb_i;
	logic        wb_we_i;
	logic [7:0]  wb_adr_i;
	logic [3:0]  wb_sel_i;
	logic [31:0] wb_dat_i;
	logic [31:0] wb_dat_o;
	logic        wb_ack_o;
	logic [7:0]  acc_o;
	logic        carry_o;
	logic        zero_o;
	logic [4:0]  bank_o;
	logic [6:0]  pc_latch_o;
	logic [12:0] pc_o;
	int          n_mismatch;
	int          checked;
	logic [31:0] v;
	logic [3:0]  sel_v;
	logic [7:0]  ea [4];
	logic [15:0] np [4];

	smie_exec dut_u (
		.clk_i      (clk_i),
		.rst_i      (rst_i),
		.wb_cyc_i   (wb_cyc_i),
		.wb_stb_i   (wb_stb_i),
		.wb_we_i    (wb_we_i),
		.wb_adr_i   (wb_adr_i),
		.wb_sel_i   (wb_sel_i),
		.wb_dat_i   (wb_dat_i),
		.wb_dat_o   (wb_dat_o),
		.wb_ack_o   (wb_ack_o),
		.acc_o      (acc_o),
		.carry_o    (carry_o),
		.zero_o     (zero_o),
		.bank_o     (bank_o),
		.pc_latch_o (pc_latch_o),
		.pc_o       (pc_o)
	);

	initial
	begin
		clk_i = 1'b0;
		forever #20 clk_i = ~clk_i;
	end

	// ********************
	// Tasks
	// ********************
	task automatic wrap_up;
		if (n_mismatch == 0 && checked > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : wrap_up

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp)
		begin
			n_mismatch++;
			$display("ERROR %0t: got %h expected %h", $time, seen, exp);
		end
	endtask : chk

	// Request held until ack is sampled; the wait is bounded
	task automatic wb_xfer(input logic we, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] q);
		int n;
		@(posedge clk_i);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i  <= we;
		wb_sel_i <= sel_v;
		wb_adr_i <= a;
		wb_dat_i <= d;
		n = 0;
		do
		begin
			@(posedge clk_i);
			n++;
		end
		while (wb_ack_o !== 1'b1 && n < 20);
		if (wb_ack_o !== 1'b1)
		begin
			n_mismatch++;
			$display("ERROR %0t: no ack", $time);
			wrap_up();
		end
		q = wb_dat_o;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
		wb_we_i  <= 1'b0;
		@(posedge clk_i);
		#1;
	endtask : wb_xfer

	task automatic wb_wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] q;
		wb_xfer(1'b1, a, d, q);
	endtask : wb_wr

	task automatic wb_rd(input logic [7:0] a, output logic [31:0] q);
		wb_xfer(1'b0, a, 32'h0000_0000, q);
	endtask : wb_rd

	task automatic run(input logic [3:0] op, input logic d, input logic ps,
		input logic [1:0] upd, input logic rel, input logic [10:0] opnd);
		smie_cmd_t c;
		c = '0;
		c.op = op;
		c.dest = d;
		c.ptr_sel = ps;
		c.pointer_update_code = upd;
		c.relative = rel;
		c.operand = opnd;
		wb_wr(ADR_CMD, c);
	endtask : run

	task automatic setcell(input logic [6:0] i, input logic [7:0] d);
		wb_wr(ADR_FADDR, {25'h0, i});
		wb_wr(ADR_FDATA, {24'h0, d});
	endtask : setcell

	task automatic getcell(input logic [6:0] i, output logic [31:0] q);
		wb_wr(ADR_FADDR, {25'h0, i});
		wb_rd(ADR_FDATA, q);
	endtask : getcell

	// ********************
	// Main sequence
	// ********************
	initial
	begin
		n_mismatch = 0;
		checked = 0;
		rst_i = 1'b1;
		wb_cyc_i = 1'b0;
		wb_stb_i = 1'b0;
		wb_we_i = 1'b0;
		wb_adr_i = 8'h00;
		wb_sel_i = 4'hf;
		sel_v = 4'hf;
		wb_dat_i = 32'h0000_0000;
		repeat (10) @(posedge clk_i);
		rst_i <= 1'b0;
		@(posedge clk_i);
		#1;
		chk({10'h0, acc_o, carry_o, zero_o, bank_o, pc_latch_o}, 32'h0);
		chk({19'h0, pc_o}, 32'h0);
		wb_rd(ADR_STATUS, v);
		chk(v, 32'h0);
		// Shift right to accumulator
		setcell(7'h40, 8'h81);
		run(OP_LOGIC_SHIFT_RIGHT, 1'b0, 1'b0, 2'b00, 1'b0, 11'h040);
		chk({22'h0, acc_o, carry_o, zero_o}, {22'h0, 8'h40, 1'b1, 1'b0});
		getcell(7'h40, v);
		chk(v, 32'h81);
		// Shift right back into the cell, result zero
		setcell(7'h41, 8'h01);
		run(OP_LOGIC_SHIFT_RIGHT, 1'b1, 1'b0, 2'b00, 1'b0, 11'h041);
		chk({22'h0, acc_o, carry_o, zero_o}, {22'h0, 8'h40, 1'b1, 1'b1});
		getcell(7'h41, v);
		chk(v, 32'h0);
		// Copy file in place tests the cell
		wb_wr(ADR_STATUS, 32'h0);
		run(OP_COPY_FILE, 1'b1, 1'b0, 2'b00, 1'b0, 11'h041);
		chk({23'h0, acc_o, zero_o}, {23'h0, 8'h40, 1'b1});
		run(OP_COPY_FILE, 1'b0, 1'b0, 2'b00, 1'b0, 11'h040);
		chk({23'h0, acc_o, zero_o}, {23'h0, 8'h81, 1'b0});
		// Indirect load, all four update codes
		ea = '{8'h22, 8'h20, 8'h21, 8'h21};
		np = '{16'h0022, 16'h0020, 16'h0022, 16'h0020};
		for (int k = 0; k < 3; k++)
			setcell(7'h20 + k[6:0], 8'ha0 + k[7:0]);
		for (int i = 0; i < 4; i++)
		begin
			wb_wr(ADR_PTR0, 32'h21);
			wb_wr(ADR_STATUS, 32'h1);
			run(OP_INDIRECT_LOAD, 1'b0, 1'b0, i[1:0], 1'b0, 11'h0);
			chk({23'h0, acc_o, carry_o}, {23'h0, ea[i] + 8'h80, 1'b1});
			wb_rd(ADR_PTR0, v);
			chk(v, {16'h0, np[i]});
		end
		// Relative offset at both ends of its range
		setcell(7'h10, 8'h3c);
		setcell(7'h4f, 8'h4d);
		wb_wr(ADR_PTR1, 32'h30);
		run(OP_INDIRECT_LOAD, 1'b0, 1'b1, 2'b00, 1'b1, 11'h020);
		chk({24'h0, acc_o}, 32'h3c);
		run(OP_INDIRECT_LOAD, 1'b0, 1'b1, 2'b10, 1'b1, 11'h01f);
		chk({24'h0, acc_o}, 32'h4d);
		wb_rd(ADR_PTR1, v);
		chk(v, 32'h30);
		// Pointer wraps both ways
		wb_wr(ADR_PTR0, 32'hffff);
		run(OP_INDIRECT_LOAD, 1'b0, 1'b0, 2'b00, 1'b0, 11'h0);
		wb_rd(ADR_PTR0, v);
		chk(v, 32'h0);
		chk({23'h0, acc_o, zero_o}, {23'h0, 8'h00, 1'b1});
		run(OP_INDIRECT_LOAD, 1'b0, 1'b0, 2'b11, 1'b0, 11'h0);
		wb_rd(ADR_PTR0, v);
		chk(v, 32'hffff);
		// Byte lanes honoured on pointer 0
		sel_v = 4'h1;
		wb_wr(ADR_PTR0, 32'h1234);
		sel_v = 4'hf;
		wb_rd(ADR_PTR0, v);
		chk(v, 32'hff34);
		// Window cells redirect through the pointers
		wb_wr(ADR_PTR0, 32'h21);
		run(OP_COPY_FILE, 1'b0, 1'b0, 2'b00, 1'b0, 11'h000);
		chk({24'h0, acc_o}, 32'ha1);
		wb_wr(ADR_PTR1, 32'h22);
		run(OP_LOGIC_SHIFT_RIGHT, 1'b1, 1'b0, 2'b00, 1'b0, 11'h001);
		getcell(7'h22, v);
		chk(v, 32'h51);
		chk({31'h0, carry_o}, 32'h0);
		// Literals leave the flags alone
		wb_wr(ADR_STATUS, 32'h1);
		run(OP_LITERAL_TO_BANK, 1'b0, 1'b0, 2'b00, 1'b0, 11'h00f);
		run(OP_LITERAL_TO_PC_LATCH, 1'b0, 1'b0, 2'b00, 1'b0, 11'h07f);
		run(OP_LITERAL_TO_ACC, 1'b0, 1'b0, 2'b00, 1'b0, 11'h000);
		chk({12'h0, bank_o, pc_latch_o, acc_o}, {12'h0, 5'h0f, 7'h7f, 8'h00});
		wb_rd(ADR_STATUS, v);
		chk(v, 32'h1);
		run(OP_LITERAL_TO_ACC, 1'b0, 1'b0, 2'b00, 1'b0, 11'h0ff);
		chk({24'h0, acc_o}, 32'hff);
		// Branch takes upper bits from the latch
		run(OP_LITERAL_TO_PC_LATCH, 1'b0, 1'b0, 2'b00, 1'b0, 11'h018);
		run(OP_BRANCH, 1'b0, 1'b0, 2'b00, 1'b0, 11'h7ff);
		chk({19'h0, pc_o}, 32'h1fff);
		run(OP_LITERAL_TO_PC_LATCH, 1'b0, 1'b0, 2'b00, 1'b0, 11'h008);
		run(OP_BRANCH, 1'b0, 1'b0, 2'b00, 1'b0, 11'h123);
		wb_rd(ADR_PC, v);
		chk(v, 32'h0923);
		// Unmapped places read zero and ignore writes
		wb_wr(8'h44, 32'h12);
		wb_rd(8'h40, v);
		chk(v, 32'h0);
		wb_rd(ADR_ACC, v);
		chk(v, 32'hff);
		wrap_up();
	end
endmodule : tb
